// ==== hw/bram_pkg.sv ====
// constants, field layout and width helpers for the embedded block memory
// assumes nothing; shared by the core and the apb register file
package bram_pkg;

    // -----------------------------------------------------------------
    // register offsets, fields and reset values
    // -----------------------------------------------------------------
    localparam logic [7:0]  OFS_CFG      = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam int          CFG_MODE_LSB = 0;
    localparam int          CFG_WIDA_LSB = 2;
    localparam int          CFG_WIDB_LSB = 6;
    localparam int          CFG_WMA_LSB  = 10;
    localparam int          CFG_WMB_LSB  = 12;
    localparam int          CFG_PIPEA    = 14;
    localparam int          CFG_PIPEB    = 15;
    localparam int          CFG_CLK_LSB  = 16;
    localparam logic [31:0] CFG_WR_MASK  = 32'h0003_FFFF;
    localparam logic [31:0] CFG_RESET    = 32'h0002_0220;
    localparam int          STAT_LEGAL   = 0;
    localparam int          STAT_COLL    = 1;

    // -----------------------------------------------------------------
    // array geometry and width codes
    // -----------------------------------------------------------------
    localparam int          ADDR_BITS = 14;
    localparam int          IDX_BITS  = 9;
    localparam int          MEM_WORDS = 512;
    localparam int          WORD_BITS = 36;
    localparam int          LANES     = 4;
    localparam logic [3:0]  W32       = 4'h5;
    localparam logic [3:0]  W9        = 4'h6;
    localparam logic [3:0]  W36       = 4'h8;

    typedef enum logic [1:0] {MODE_SINGLE = 2'h0, MODE_DUAL = 2'h1, MODE_SEMI = 2'h2} portMode_t;
    typedef enum logic [1:0] {WR_NORMAL = 2'h0, WR_THROUGH = 2'h1, WR_RBW = 2'h2} writeMode_t;
    typedef enum logic [1:0] {CLK_INDEP = 2'h0, CLK_RDWR = 2'h1, CLK_SINGLE = 2'h2} clockMode_t;

    // codes 0..5 are 1..32 bit words, 6..8 are 9, 18, 36 bit words
    function automatic logic isNine(input logic [3:0] code);
        isNine = (code >= W9);
    endfunction

    // log2 of the width inside its own group
    function automatic logic [2:0] groupLog(input logic [3:0] code);
        groupLog = isNine(code) ? 3'(code - W9) : code[2:0];
    endfunction

endpackage

// ==== hw/bram_out_stage.sv ====
// read output stage: optional pipeline register in front of the data output
// assumes the array output it receives is already a flip-flop
`timescale 1ns/1ps
module bram_out_stage (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // array side
    input  wire logic [35:0] arrayData,
    input  wire logic        pipeEn,
    // user side
    output logic      [35:0] rdata
);
    logic [35:0] pipe_q;
    logic [35:0] pipe_d;

    // pipeline stage always runs; the mode only picks the tap
    always_comb begin
        pipe_d = arrayData;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pipe_q <= 36'h0_0000_0000;
        end else begin
            pipe_q <= pipe_d;
        end
    end

    // one cycle later when pipelined, array register when bypassed
    assign rdata = pipeEn ? pipe_q : arrayData;
endmodule

// ==== hw/bram_apb_regs.sv ====
// apb register file: configuration word, legality check and collision flag
// assumes an apb master on clk_sys; answers with zero wait states
`timescale 1ns/1ps
module bram_apb_regs (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // core side
    input  wire logic        collisionPulse,
    output logic      [31:0] cfgWord,
    output logic             cfgLegal
);
    logic [31:0] cfg_q, cfg_d, prdata_q, prdata_d;
    logic        coll_q, coll_d, slverr_q, slverr_d;
    logic [3:0]  wa, wb;
    logic [1:0]  md, ck, ma;
    logic        narrowPair, ninePair;

    // -----------------------------------------------------------------
    // legality of the configured width, write mode and clock pairing
    // -----------------------------------------------------------------
    always_comb begin
        md = cfg_q[bram_pkg::CFG_MODE_LSB +: 2];
        wa = cfg_q[bram_pkg::CFG_WIDA_LSB +: 4];
        wb = cfg_q[bram_pkg::CFG_WIDB_LSB +: 4];
        ma = cfg_q[bram_pkg::CFG_WMA_LSB +: 2];
        ck = cfg_q[bram_pkg::CFG_CLK_LSB +: 2];
        narrowPair = !bram_pkg::isNine(wa) && !bram_pkg::isNine(wb);
        ninePair = bram_pkg::isNine(wa) && bram_pkg::isNine(wb) && wb != bram_pkg::W36;
        cfgLegal = 1'b0;
        case (md)
            bram_pkg::MODE_SINGLE:
                cfgLegal = wa <= bram_pkg::W36 && ma != 2'h3 && ck == bram_pkg::CLK_SINGLE;
            bram_pkg::MODE_DUAL:
                cfgLegal = (narrowPair || ninePair) && wa != bram_pkg::W32 && wb != bram_pkg::W32
                    && wa != bram_pkg::W36 && ma <= 2'h1
                    && cfg_q[bram_pkg::CFG_WMB_LSB +: 2] <= 2'h1
                    && (ck == bram_pkg::CLK_INDEP || ck == bram_pkg::CLK_RDWR);
            bram_pkg::MODE_SEMI:
                cfgLegal = (narrowPair || ninePair) && wa <= bram_pkg::W36
                    && ma == bram_pkg::WR_NORMAL && ck == bram_pkg::CLK_RDWR;
            default:
                cfgLegal = 1'b0;
        endcase
    end

    // -----------------------------------------------------------------
    // apb decode
    // -----------------------------------------------------------------
    // read data sampled in setup so prdata comes from a flop in access
    always_comb begin
        cfg_d = cfg_q;
        coll_d = coll_q;
        prdata_d = prdata_q;
        slverr_d = slverr_q;
        if (psel && penable && pwrite && paddr == bram_pkg::OFS_CFG) begin
            cfg_d = pwdata & bram_pkg::CFG_WR_MASK;
        end
        if (psel && penable && pwrite && paddr == bram_pkg::OFS_STATUS && pwdata[bram_pkg::STAT_COLL]) begin
            coll_d = 1'b0;
        end
        if (collisionPulse) begin
            coll_d = 1'b1;  // set wins over a clear in the same cycle
        end
        if (psel && !penable) begin
            slverr_d = 1'b0;
            case (paddr)
                bram_pkg::OFS_CFG:    prdata_d = cfg_q;
                bram_pkg::OFS_STATUS: prdata_d = {30'h0000_0000, coll_q, cfgLegal};
                default: begin
                    prdata_d = 32'h0000_0000;
                    slverr_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_q <= bram_pkg::CFG_RESET;
            coll_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            coll_q <= coll_d;
            prdata_q <= prdata_d;
            slverr_q <= slverr_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel & penable & slverr_q;
    assign cfgWord = cfg_q;
endmodule

// ==== hw/embedded_block_memory.sv ====
// embedded block memory: 18 Kbit array, two user ports, apb configuration
// assumes port logic and apb master both run on clk_sys; the array has no reset
`timescale 1ns/1ps
module embedded_block_memory (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // port a
    input  wire logic [13:0] portAAddr,
    input  wire logic [35:0] portAWdata,
    input  wire logic [3:0]  portAByteEn,
    input  wire logic        portAWriteEnable,
    input  wire logic        portAReadEnable,
    output logic      [35:0] portARdata,
    // port b
    input  wire logic [13:0] portBAddr,
    input  wire logic [35:0] portBWdata,
    input  wire logic [3:0]  portBByteEn,
    input  wire logic        portBWriteEnable,
    input  wire logic        portBReadEnable,
    output logic      [35:0] portBRdata
);

    // -----------------------------------------------------------------
    // word and sub-word helpers
    // -----------------------------------------------------------------
    // data bits of a 36 bit word without the ninth bits
    function automatic logic [31:0] pack32(input logic [35:0] w);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int k = 0; k < bram_pkg::LANES; k++) begin
            r[8*k +: 8] = w[9*k +: 8];
        end
        return r;
    endfunction

    // put 32 data bits back, ninth bits untouched
    function automatic logic [35:0] unpack32(input logic [35:0] old, input logic [31:0] d);
        logic [35:0] r;
        r = old;
        for (int k = 0; k < bram_pkg::LANES; k++) begin
            r[9*k +: 8] = d[8*k +: 8];
        end
        return r;
    endfunction

    // low address bits that select a sub-word inside the 36 bit word
    function automatic logic [2:0] subBits(input logic [3:0] code);
        subBits = bram_pkg::isNine(code) ? 3'(3'h2 - bram_pkg::groupLog(code))
                                         : 3'(3'h5 - bram_pkg::groupLog(code));
    endfunction

    function automatic logic [5:0] unitWidth(input logic [3:0] code);
        unitWidth = bram_pkg::isNine(code) ? 6'(6'h09 << bram_pkg::groupLog(code))
                                           : 6'(6'h01 << bram_pkg::groupLog(code));
    endfunction

    function automatic logic [35:0] widthMask(input logic [3:0] code);
        widthMask = ~(36'hF_FFFF_FFFF << unitWidth(code));
    endfunction

    // address masked to log2 of the depth, then shifted to a word index
    function automatic logic [8:0] wordIdx(input logic [3:0] code, input logic [13:0] addr);
        logic [3:0]  aw;
        logic [13:0] m;
        aw = bram_pkg::isNine(code) ? 4'(4'hB - bram_pkg::groupLog(code))
                                    : 4'(4'hE - bram_pkg::groupLog(code));
        m = addr & 14'(~(14'h3FFF << aw));
        return 9'(m >> subBits(code));
    endfunction

    // lsb-first bit offset of the sub-word inside its view
    function automatic logic [5:0] unitShift(input logic [3:0] code, input logic [13:0] addr);
        logic [4:0] sub;
        sub = addr[4:0] & 5'(~(5'h1F << subBits(code)));
        return 6'(sub * unitWidth(code));
    endfunction

    // view is the 36 bit word for the nine group, 32 data bits otherwise
    function automatic logic [35:0] readUnit(input logic [3:0] code, input logic [35:0] w,
                                             input logic [13:0] addr);
        logic [35:0] view;
        view = bram_pkg::isNine(code) ? w : {4'h0, pack32(w)};
        return (view >> unitShift(code, addr)) & widthMask(code);
    endfunction

    // merge a sub-word into the stored word; the byte mask applies only to sub-words wider than 9 bits
    function automatic logic [35:0] mergeWrite(input logic [3:0] code, input logic [35:0] old,
                                               input logic [13:0] addr, input logic [35:0] d,
                                               input logic [3:0] be);
        logic [35:0] view, dm, bm, nv;
        logic [5:0]  sh;
        logic [3:0]  lanes;
        logic        wide;
        sh = unitShift(code, addr);
        view = bram_pkg::isNine(code) ? old : {4'h0, pack32(old)};
        wide = unitWidth(code) > 6'h09;
        lanes = bram_pkg::isNine(code) ? 4'(be << (sh / 6'h09)) : 4'(be << (sh / 6'h08));
        bm = 36'h0_0000_0000;
        for (int k = 0; k < bram_pkg::LANES; k++) begin
            if (!wide || lanes[k]) begin
                if (bram_pkg::isNine(code)) begin
                    bm[9*k +: 9] = 9'h1FF;
                end else begin
                    bm[8*k +: 8] = 8'hFF;
                end
            end
        end
        dm = (widthMask(code) << sh) & bm;
        nv = (view & ~dm) | ((d << sh) & dm);
        return bram_pkg::isNine(code) ? nv : unpack32(old, nv[31:0]);
    endfunction

    // -----------------------------------------------------------------
    // configuration from the register file
    // -----------------------------------------------------------------
    logic [31:0]            cfgWord;
    logic                   cfgLegal;
    logic                   collision;
    bram_pkg::portMode_t    mode;
    logic [3:0]             portCode [2];
    bram_pkg::writeMode_t   wrMode   [2];
    logic                   pipeEn   [2];
    logic                   wrOk     [2];
    logic                   rdOk     [2];

    bram_apb_regs u_regs (
        .clk_sys        (clk_sys),
        .rst            (rst),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .collisionPulse (collision),
        .cfgWord        (cfgWord),
        .cfgLegal       (cfgLegal)
    );

    // illegal pairings freeze the array; port roles follow the mode
    always_comb begin
        mode = bram_pkg::portMode_t'(cfgWord[bram_pkg::CFG_MODE_LSB +: 2]);
        portCode[0] = cfgWord[bram_pkg::CFG_WIDA_LSB +: 4];
        portCode[1] = cfgWord[bram_pkg::CFG_WIDB_LSB +: 4];
        wrMode[0] = bram_pkg::writeMode_t'(cfgWord[bram_pkg::CFG_WMA_LSB +: 2]);
        wrMode[1] = bram_pkg::writeMode_t'(cfgWord[bram_pkg::CFG_WMB_LSB +: 2]);
        pipeEn[0] = cfgWord[bram_pkg::CFG_PIPEA];
        pipeEn[1] = cfgWord[bram_pkg::CFG_PIPEB];
        wrOk[0] = cfgLegal;
        wrOk[1] = cfgLegal && mode == bram_pkg::MODE_DUAL;
        rdOk[0] = cfgLegal && mode != bram_pkg::MODE_SEMI;
        rdOk[1] = cfgLegal && mode != bram_pkg::MODE_SINGLE;
    end

    // -----------------------------------------------------------------
    // input registers
    // -----------------------------------------------------------------
    logic [13:0] inAddr [2];
    logic [35:0] inData [2];
    logic [3:0]  inBe   [2];
    logic        inWe   [2];
    logic        inRe   [2];
    logic [13:0] addr_q [2], addr_d [2];
    logic [35:0] data_q [2], data_d [2];
    logic [3:0]  be_q   [2], be_d   [2];
    logic        we_q   [2], we_d   [2];
    logic        re_q   [2], re_d   [2];

    assign inAddr[0] = portAAddr;
    assign inAddr[1] = portBAddr;
    assign inData[0] = portAWdata;
    assign inData[1] = portBWdata;
    assign inBe[0] = portAByteEn;
    assign inBe[1] = portBByteEn;
    assign inWe[0] = portAWriteEnable;
    assign inWe[1] = portBWriteEnable;
    assign inRe[0] = portAReadEnable;
    assign inRe[1] = portBReadEnable;

    // one clock serves both ports, so each port keeps its own register set
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            addr_d[p] = inAddr[p];
            data_d[p] = inData[p];
            be_d[p] = inBe[p];
            we_d[p] = inWe[p] && wrOk[p];
            re_d[p] = inRe[p] && rdOk[p];
        end
    end

    always_ff @(posedge clk_sys) begin
        for (int p = 0; p < 2; p++) begin
            if (rst) begin
                addr_q[p] <= 14'h0000;
                data_q[p] <= 36'h0_0000_0000;
                be_q[p] <= 4'h0;
                we_q[p] <= 1'b0;
                re_q[p] <= 1'b0;
            end else begin
                addr_q[p] <= addr_d[p];
                data_q[p] <= data_d[p];
                be_q[p] <= be_d[p];
                we_q[p] <= we_d[p];
                re_q[p] <= re_d[p];
            end
        end
    end

    // -----------------------------------------------------------------
    // array and registered array output
    // -----------------------------------------------------------------
    logic [35:0] mem [bram_pkg::MEM_WORDS];
    logic [8:0]  idx      [2];
    logic [35:0] oldWord  [2];
    logic [35:0] newWord  [2];
    logic [35:0] arrOut_q [2], arrOut_d [2];

    // read and write share one edge; the write mode picks what the output shows
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            idx[p] = wordIdx(portCode[p], addr_q[p]);
            oldWord[p] = mem[idx[p]];
            newWord[p] = mergeWrite(portCode[p], oldWord[p], addr_q[p], data_q[p], be_q[p]);
            arrOut_d[p] = arrOut_q[p];
            if (we_q[p]) begin
                case (wrMode[p])
                    bram_pkg::WR_THROUGH: arrOut_d[p] = readUnit(portCode[p], newWord[p],
                                                                 addr_q[p]);
                    bram_pkg::WR_RBW:     arrOut_d[p] = readUnit(portCode[p], oldWord[p],
                                                                 addr_q[p]);
                    default:              arrOut_d[p] = arrOut_q[p];
                endcase
            end else if (re_q[p]) begin
                arrOut_d[p] = readUnit(portCode[p], oldWord[p], addr_q[p]);
            end
        end
    end

    // array holds no reset; port b lands last if both write one word
    always_ff @(posedge clk_sys) begin
        for (int p = 0; p < 2; p++) begin
            if (we_q[p]) begin
                mem[idx[p]] <= newWord[p];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        for (int p = 0; p < 2; p++) begin
            if (rst) begin
                arrOut_q[p] <= 36'h0_0000_0000;
            end else begin
                arrOut_q[p] <= arrOut_d[p];
            end
        end
    end

    // same-word traffic with a write is the user's fault; flagged, not resolved
    assign collision = (idx[0] == idx[1]) &&
                       ((we_q[0] && (we_q[1] || re_q[1])) || (we_q[1] && re_q[0]));

    // -----------------------------------------------------------------
    // output stages
    // -----------------------------------------------------------------
    bram_out_stage u_outA (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .arrayData (arrOut_q[0]),
        .pipeEn    (pipeEn[0]),
        .rdata     (portARdata)
    );

    bram_out_stage u_outB (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .arrayData (arrOut_q[1]),
        .pipeEn    (pipeEn[1]),
        .rdata     (portBRdata)
    );

endmodule

// ==== verif/bram_props.sv ====
// checker: port timing of the block memory in single and semi-dual use
// assumes it is bound to embedded_block_memory and sees only its ports
`timescale 1ns/1ps
module bram_props (
    // clock, reset, apb
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    // user ports
    input wire logic [13:0] portAAddr,
    input wire logic [35:0] portAWdata,
    input wire logic [3:0]  portAByteEn,
    input wire logic        portAWriteEnable,
    input wire logic        portAReadEnable,
    input wire logic [35:0] portARdata,
    input wire logic [35:0] portBRdata
);
    // --------------------------------------------------------------
    // configuration shadow
    // --------------------------------------------------------------
    logic [17:0] cfg_d;
    logic [17:0] cfg_q;
    // follows apb writes so the properties know the mode in force
    assign cfg_d = (psel && penable && pwrite && paddr == 8'h00) ? pwdata[17:0] : cfg_q;
    always_ff @(posedge clk_sys) begin
        cfg_q <= rst ? 18'h2_0220 : cfg_d;
    end
    wire [1:0] pm   = cfg_q[1:0];
    wire [1:0] wm   = cfg_q[11:10];
    wire       pipe = cfg_q[14];
    // single use at 36 bits: legal, so enables are honoured
    wire       sp   = pm == 2'h0 && cfg_q[5:2] == 4'h8 && cfg_q[9:6] <= 4'h8
                      && cfg_q[17:16] == 2'h2 && wm != 2'h3;
    // --------------------------------------------------------------
    // properties
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_wr; sp && portAWriteEnable && portAByteEn == 4'hF; endsequence
    sequence s_rd; sp && portAReadEnable && !portAWriteEnable && !pipe; endsequence
    property p_norm; s_wr ##0 (wm == 2'h0 && !pipe) |=> ##1 $stable(portARdata); endproperty
    property p_thru;
        s_wr ##0 (wm == 2'h1 && !pipe) |=> ##1 portARdata == $past(portAWdata, 2);
    endproperty
    property p_rbw;
        s_wr ##0 (wm == 2'h2 && !pipe) ##1 s_wr ##0 $stable(portAAddr)
            |=> ##1 portARdata == $past(portAWdata, 3);
    endproperty
    property p_pipe;
        s_wr ##0 (wm == 2'h1 && pipe) |=> ##2 portARdata == $past(portAWdata, 3);
    endproperty
    property p_keep;
        s_wr ##1 s_rd ##0 $stable(portAAddr) |=> ##1 portARdata == $past(portAWdata, 3);
    endproperty
    // a reset edge may clear the output, hence the check on the previous reset
    property p_bIdle; pm == 2'h0 && $past(pm) == 2'h0 && !$past(rst) |-> $stable(portBRdata);
    endproperty
    property p_aHold; pm == 2'h2 && $past(pm) == 2'h2 |-> $stable(portARdata); endproperty
    property p_err; psel && penable && paddr[7:3] != 5'h00 |-> pslverr; endproperty
    a_norm: assert property (p_norm) else $error("normal write moved output");
    a_thru: assert property (p_thru) else $error("write data not shown");
    a_rbw: assert property (p_rbw) else $error("old data not shown");
    a_pipe: assert property (p_pipe) else $error("pipeline timing wrong");
    a_keep: assert property (p_keep) else $error("stored word lost");
    a_bIdle: assert property (p_bIdle) else $error("port b active in single");
    a_aHold: assert property (p_aHold) else $error("port a output moved");
    a_err: assert property (p_err) else $error("no slave error");
endmodule
bind embedded_block_memory bram_props i_props (.clk_sys, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pslverr, .portAAddr, .portAWdata, .portAByteEn, .portAWriteEnable,
    .portAReadEnable, .portARdata, .portBRdata);

// ==== verif/bram_user_logic.sv ====
// user fabric model: one port request per cycle on the memory ports
// assumes clk_sys is the memory clock; idle lines show inverted data
`timescale 1ns/1ps
module bram_user_logic (
    // clock
    input  wire logic        clk_sys,
    // port a
    output logic      [13:0] portAAddr,
    output logic      [35:0] portAWdata,
    output logic      [3:0]  portAByteEn,
    output logic             portAWriteEnable,
    output logic             portAReadEnable,
    // port b
    output logic      [13:0] portBAddr,
    output logic      [35:0] portBWdata,
    output logic      [3:0]  portBByteEn,
    output logic             portBWriteEnable,
    output logic             portBReadEnable
);
    // --------------------------------------------------------------
    // request tasks
    // --------------------------------------------------------------
    initial begin
        {portAAddr, portAWdata, portAByteEn, portAWriteEnable, portAReadEnable} = '0;
        {portBAddr, portBWdata, portBByteEn, portBWriteEnable, portBReadEnable} = '0;
    end
    // one port at a time, so a read never meets a write on one address
    task automatic req(input logic p, w, input logic [13:0] a, input logic [35:0] d,
                       input logic [3:0] e);
        @(posedge clk_sys);
        {portAWriteEnable, portAReadEnable} <= {!p && w, !p && !w};
        {portBWriteEnable, portBReadEnable} <= {p && w, p && !w};
        {portAAddr, portAWdata, portAByteEn} <= p ? ~{portAAddr, portAWdata, portAByteEn} : {a, d, e};
        {portBAddr, portBWdata, portBByteEn} <= p ? {a, d, e} : ~{portBAddr, portBWdata, portBByteEn};
    endtask
    // release: enables low, address and data lines no longer show the last value
    task automatic rel();
        @(posedge clk_sys);
        {portAWriteEnable, portAReadEnable, portBWriteEnable, portBReadEnable} <= 4'h0;
        {portAAddr, portAWdata, portBAddr, portBWdata} <= ~{portAAddr, portAWdata, portBAddr, portBWdata};
    endtask
endmodule

// ==== verif/test_embedded_block_memory.sv ====
// bench: apb set-up and port traffic against the block memory
// assumes the user model and checker are compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin badCount++; \
    $display("ERROR %0t got %h want %h", $time, a, e); end end
module test_embedded_block_memory;
    logic        clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, portAWriteEnable, portAReadEnable, portBWriteEnable, portBReadEnable;
    logic [13:0] portAAddr, portBAddr;
    logic [35:0] portAWdata, portBWdata, portARdata, portBRdata;
    logic [3:0]  portAByteEn, portBByteEn;
    int          badCount = 0, samplesChecked = 0;
    localparam logic [35:0] D1 = 36'h9ABCDEF01, D2 = 36'h123456789;
    // mode, widths, write mode and clock mode pairs with their legality
    logic [31:0] tbl [12] = '{32'h0000_0101, 32'h0001_01D9, 32'h0001_0191, 32'h0001_0015,
        32'h0001_0016, 32'h0001_01E2, 32'h0001_0222, 32'h0000_0016, 32'h0001_0220,
        32'h0000_0901, 32'h0001_0416, 32'h0000_0501};
    logic [11:0] lg = 12'b1000_0011_0011;
    embedded_block_memory i_dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .portAAddr, .portAWdata, .portAByteEn, .portAWriteEnable,
        .portAReadEnable, .portARdata, .portBAddr, .portBWdata, .portBByteEn,
        .portBWriteEnable, .portBReadEnable, .portBRdata);
    bram_user_logic u (.clk_sys, .portAAddr, .portAWdata, .portAByteEn, .portAWriteEnable,
        .portAReadEnable, .portBAddr, .portBWdata, .portBByteEn, .portBWriteEnable,
        .portBReadEnable);
    // --------------------------------------------------------------
    // clock and tasks
    // --------------------------------------------------------------
    always #5 clk_sys = ~clk_sys;
    task automatic tally_and_finish();
        if (badCount == 0 && samplesChecked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // apb transfer; the wait is bounded so a dead slave cannot hang the run
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        {psel, penable} <= 2'b00;
        if (n >= 20) begin
            badCount++;
            $display("ERROR %0t apb timeout", $time);
            tally_and_finish();
        end
    endtask
    // one port request, then the output checked after the set latency
    task automatic op(input logic p, w, input logic [13:0] a, input logic [35:0] d,
                      input logic [3:0] e, input int lat, input logic [35:0] x);
        u.req(p, w, a, d, e);
        u.rel();
        repeat (lat) @(posedge clk_sys);
        #1;
        `CHK(p ? portBRdata : portARdata, x)
    endtask
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            `CHK(q, i == 0 ? 32'h0002_0220 : 32'(i == 1))
        end
        op(0, 1, 14'h5, D1, 4'hF, 1, 36'h0);
        op(0, 0, 14'h5, '0, 4'h0, 1, D1);
        op(0, 1, 14'h5, D2, 4'h1, 1, D1);
        op(1, 1, 14'h5, D2, 4'hF, 1, 36'h0);
        op(0, 0, 14'h5, '0, 4'h0, 1, {D1[35:9], D2[8:0]});
        apb(1'b1, 8'h00, 32'h0002_0620);
        op(0, 1, 14'h5, D1, 4'hF, 1, D1);
        apb(1'b1, 8'h00, 32'h0002_0A20);
        op(0, 1, 14'h5, D2, 4'hF, 1, D1);
        op(0, 1, 14'h5, D1, 4'hF, 1, D2);
        apb(1'b1, 8'h00, 32'h0002_4620);
        op(0, 1, 14'h5, D1, 4'hF, 1, D2);
        op(0, 0, 14'h5, '0, 4'h0, 2, D1);
        foreach (tbl[i]) begin
            apb(1'b1, 8'h00, tbl[i]);
            apb(1'b0, 8'h04, 32'h0);
            `CHK(q[0], lg[i])
        end
        apb(1'b1, 8'h00, 32'h0001_00D6);
        op(0, 1, 14'h3, 36'h4433_2211, 4'hF, 1, D1);
        op(1, 0, 14'd14, '0, 4'h0, 1, 36'h33);
        op(1, 0, 14'd12, '0, 4'h0, 1, 36'h11);
        tally_and_finish();
    end
endmodule
